// *** hw/dlr_pkg.sv ***
// constants and state type shared by the lut ram and the decode cell
package dlr_pkg;
  localparam int ADDR_W   = 5;
  localparam int DATA_W   = 4;
  localparam int WORDS    = 32;
  localparam int DBC_BITS = 10;
  localparam int DIR_W    = 3;
  // buffer group numbers inside the decode cell
  localparam int GRP_NIB_LO = 0;
  localparam int GRP_NIB_HI = 1;
  localparam int GRP_PAIR   = 2;
  // group mode bits: bit 2 is bits 3:0, bit 1 bits 7:4, bit 0 bits 9:8
  localparam logic [2:0] MODE_ALL_BUF = 3'h0;
  localparam logic [2:0] MODE_TWO     = 3'h1;
  localparam logic [2:0] MODE_FOUR    = 3'h3;
  localparam logic [2:0] MODE_ALL_DEC = 3'h7;
  // buffer direction codes per group
  localparam logic [2:0] DIR_L2R  = 3'h0;
  localparam logic [2:0] DIR_R2L  = 3'h1;
  localparam logic [2:0] DIR_C2L  = 3'h2;
  localparam logic [2:0] DIR_C2R  = 3'h3;
  localparam logic [2:0] DIR_C2LR = 3'h4;
  // reset values
  localparam logic RST_CLK_PREV = 1'b0;
  localparam logic RST_PENDING  = 1'b0;
  localparam logic [ADDR_W-1:0] RST_WADDR = 5'h00;
  localparam logic [DATA_W-1:0] RST_WDATA = 4'h0;
  localparam logic [DATA_W-1:0] RST_QNIB  = 4'h0;

  typedef struct packed {
    logic [WORDS-1:0][DATA_W-1:0] mem;
    logic                         clkPrev;
    logic [ADDR_W-1:0]            wAddr;
    logic [DATA_W-1:0]            wData;
    logic                         commitPending;
    logic [DATA_W-1:0]            qNib;
  } dlr_lu_state_t;
endpackage

// *** hw/dlr_decode_buffer_cell.sv ***
// decode cell: ten two-way buffers and an and-or-invert decoder
`timescale 1ns/100ps
`default_nettype none
module dlr_decode_buffer_cell
  import dlr_pkg::*;
(
  input  wire logic [DBC_BITS-1:0] leftSideIn,
  input  wire logic [DBC_BITS-1:0] rightSideIn,
  input  wire logic [DBC_BITS-1:0] centralIn,
  input  wire logic                hizControl,
  input  wire logic [2:0]          groupDecoder,
  input  wire logic [3*DIR_W-1:0]  groupDir,
  input  wire logic [DBC_BITS-1:0] decInvert,
  input  wire logic                aoiUseOr,
  input  wire logic                aoiInvert,
  input  wire logic                aoiConst,
  input  wire logic [1:0]          nibHizInvert,
  input  wire logic [1:0]          nibHizDisable,
  input  wire logic [1:0]          nibUseAoi,
  input  wire logic                gateAoiWithHiz,
  output logic      [DBC_BITS-1:0] leftSideOut,
  output logic      [DBC_BITS-1:0] leftSideOutEn,
  output logic      [DBC_BITS-1:0] rightSideOut,
  output logic      [DBC_BITS-1:0] rightSideOutEn,
  output logic                     aoiOutput
);
  logic [DBC_BITS-1:0] term;
  logic [2:0]          grpAnd;
  logic [2:0]          grpDec;
  logic                gateOut;
  logic [1:0]          nibOn;
  logic [2:0]          grpOn;

  assign term = leftSideIn ^ decInvert;
  assign grpDec = {groupDecoder[0], groupDecoder[1], groupDecoder[2]};
  assign grpAnd[GRP_NIB_LO] = &term[3:0];
  assign grpAnd[GRP_NIB_HI] = &term[7:4];
  assign grpAnd[GRP_PAIR]   = &term[9:8];
  assign gateOut = aoiUseOr ? |(grpAnd & grpDec)
                            : &(grpAnd | ~grpDec);
  // constant source when all groups buffer
  assign aoiOutput = (grpDec == 3'h0) ? aoiConst : (gateOut ^ aoiInvert);

  // nibble enable from hiz or aoi output
  // aoi gated with the hiz input
  always_comb begin
    for (int n = 0; n < 2; n++) begin
      nibOn[n] = nibHizDisable[n] |
                 (nibHizInvert[n] ^
                  (nibUseAoi[n] ? (aoiOutput & (hizControl | ~gateAoiWithHiz))
                                : hizControl));
    end
  end

  assign grpOn = {1'b1, nibOn};

  genvar i;
  generate
    for (i = 0; i < DBC_BITS; i++) begin : g_buf
      localparam int G = (i < 4) ? GRP_NIB_LO :
                         ((i < 8) ? GRP_NIB_HI : GRP_PAIR);
      logic [DIR_W-1:0] dir;
      logic             on;
      assign dir = groupDir[G*DIR_W +: DIR_W];
      assign on = ~grpDec[G] & grpOn[G];
      assign rightSideOut[i] = (dir == DIR_L2R) ? leftSideIn[i] : centralIn[i];
      assign leftSideOut[i]  = (dir == DIR_R2L) ? rightSideIn[i] : centralIn[i];
      assign rightSideOutEn[i] = on & ((dir == DIR_L2R) | (dir == DIR_C2R) |
                                       (dir == DIR_C2LR));
      assign leftSideOutEn[i]  = on & ((dir == DIR_R2L) | (dir == DIR_C2L) |
                                       (dir == DIR_C2LR));
    end
  endgenerate
endmodule // dlr_decode_buffer_cell
`default_nettype wire

// *** hw/dlr_logic_unit.sv ***
// logic unit in memory mode: 32x4 dual-port ram with its decode cell
//
// How it works
// - 32 words of 4 bits, separate ports
// - read data combinational and registered, even bits
// - write strobe plus two port enables, one clock
// - clock, strobe, enables polarity; enables disableable
// - capture on active edge, commit half cycle later
// - read port is asynchronous
// - initial contents; write disabled gives rom
// - decode cell decodes bank, gates read drivers
// - read enable floats read data bus
// - decode cell has ten buffers, three groups
// - buffers drive left, right or from centre
// - only nibble groups have three-state
// - one hiz input, per-nibble invert or disable
// - aoi output as constant in buffer mode
// - nibble and pair ands into and/or gate
// - eight modes, each group buffer or decoder
// - aoi gated with hiz enables buffers
//
// Design decisions made here: strobed register access and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module dlr_logic_unit
  import dlr_pkg::*;
#(
  parameter int                          NUM_WORDS = WORDS,
  parameter int                          WORD_W    = DATA_W,
  parameter logic [WORDS*DATA_W-1:0]     INIT_CONTENT = '0
)
(
  input  wire logic                mclk,
  input  wire logic                rst,
  input  wire logic                pfuClk,
  input  wire logic [3:0]          lutInputBus,
  input  wire logic                fifthLutInput,
  input  wire logic                carryInPort,
  input  wire logic [7:0]          directDataIn,
  input  wire logic                writeStrobeInput,
  input  wire logic                secondPortEnable,
  input  wire logic                thirdPortEnable,
  input  wire logic                clkInvert,
  input  wire logic                strobeInvert,
  input  wire logic                secondEnInvert,
  input  wire logic                thirdEnInvert,
  input  wire logic                secondEnDisable,
  input  wire logic                thirdEnDisable,
  input  wire logic                writeDisable,
  input  wire logic [DBC_BITS-1:0] leftSideIn,
  input  wire logic [DBC_BITS-1:0] rightSideIn,
  input  wire logic                hizControl,
  input  wire logic [2:0]          groupDecoder,
  input  wire logic [3*DIR_W-1:0]  groupDir,
  input  wire logic [DBC_BITS-1:0] decInvert,
  input  wire logic                aoiUseOr,
  input  wire logic                aoiInvert,
  input  wire logic                aoiConst,
  input  wire logic [1:0]          nibHizInvert,
  input  wire logic [1:0]          nibHizDisable,
  input  wire logic [1:0]          nibUseAoi,
  input  wire logic                gateAoiWithHiz,
  output logic      [7:0]          result,
  output logic      [7:0]          registeredOut,
  output logic      [DBC_BITS-1:0] leftSideOut,
  output logic      [DBC_BITS-1:0] leftSideOutEn,
  output logic      [DBC_BITS-1:0] rightSideOut,
  output logic      [DBC_BITS-1:0] rightSideOutEn,
  output logic                     aoiOutput
);
  generate
    if (NUM_WORDS != WORDS || WORD_W != DATA_W) begin : g_bad_size
      $error("dlr_logic_unit supports only 32 words of 4 bits");
    end
  endgenerate

  dlr_lu_state_t st;
  dlr_lu_state_t next_st;

  logic [ADDR_W-1:0]   readAddr;
  logic [ADDR_W-1:0]   writeAddr;
  logic [DATA_W-1:0]   writeData;
  logic [DATA_W-1:0]   rdNib;
  logic                rise;
  logic                fall;
  logic                activeEdge;
  logic                oppEdge;
  logic                wrOk;
  logic [DBC_BITS-1:0] centralIn;

  assign readAddr[ADDR_W-1] = fifthLutInput;
  assign readAddr[3:0]      = lutInputBus;
  assign writeAddr[ADDR_W-1] = carryInPort;

  genvar b;
  generate
    for (b = 0; b < DATA_W; b++) begin : g_bits
      assign writeAddr[b]          = directDataIn[2*b+1];
      assign writeData[b]          = directDataIn[2*b];
      assign result[2*b]           = rdNib[b];
      assign result[2*b+1]         = 1'b0;
      assign registeredOut[2*b]    = st.qNib[b];
      assign registeredOut[2*b+1]  = 1'b0;
    end
  endgenerate

  assign rdNib = st.mem[readAddr];

  assign rise       = pfuClk & ~st.clkPrev;
  assign fall       = ~pfuClk & st.clkPrev;
  assign activeEdge = clkInvert ? fall : rise;
  assign oppEdge    = clkInvert ? rise : fall;

  // strobe and every enabled port enable
  assign wrOk = ~writeDisable &
                (writeStrobeInput ^ strobeInvert) &
                (secondEnDisable | (secondPortEnable ^ secondEnInvert)) &
                (thirdEnDisable | (thirdPortEnable ^ thirdEnInvert));

  always_comb begin
    next_st         = st;
    next_st.clkPrev = pfuClk;
    if (activeEdge) begin
      next_st.wAddr         = writeAddr;
      next_st.wData         = writeData;
      next_st.commitPending = wrOk;
      next_st.qNib          = rdNib;
    end
    if (oppEdge && st.commitPending) begin
      next_st.mem[st.wAddr] = st.wData;
      next_st.commitPending = 1'b0;
    end
  end

  // contents loaded from the init image
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      st.mem           <= INIT_CONTENT;
      st.clkPrev       <= RST_CLK_PREV;
      st.wAddr         <= RST_WADDR;
      st.wData         <= RST_WDATA;
      st.commitPending <= RST_PENDING;
      st.qNib          <= RST_QNIB;
    end else begin
      st <= next_st;
    end
  end

  // central inputs: read data, registered data, pending flag and captured address msb
  assign centralIn = {st.wAddr[ADDR_W-1], st.commitPending, st.qNib, rdNib};

  // bank decode and read enable in the cell
  dlr_decode_buffer_cell u_cell (
    .leftSideIn     (leftSideIn),
    .rightSideIn    (rightSideIn),
    .centralIn      (centralIn),
    .hizControl     (hizControl),
    .groupDecoder   (groupDecoder),
    .groupDir       (groupDir),
    .decInvert      (decInvert),
    .aoiUseOr       (aoiUseOr),
    .aoiInvert      (aoiInvert),
    .aoiConst       (aoiConst),
    .nibHizInvert   (nibHizInvert),
    .nibHizDisable  (nibHizDisable),
    .nibUseAoi      (nibUseAoi),
    .gateAoiWithHiz (gateAoiWithHiz),
    .leftSideOut    (leftSideOut),
    .leftSideOutEn  (leftSideOutEn),
    .rightSideOut   (rightSideOut),
    .rightSideOutEn (rightSideOutEn),
    .aoiOutput      (aoiOutput)
  );

  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  sequence s_capture;
    activeEdge && wrOk;
  endsequence

  sequence s_commit;
    oppEdge && st.commitPending;
  endsequence

  property p_capture_arms;
    s_capture |=> st.commitPending && st.wAddr == $past(writeAddr) &&
                  st.wData == $past(writeData);
  endproperty
  a_capture_arms: assert property (p_capture_arms)
    else $error("write not captured on active edge");

  property p_commit_word;
    s_commit |=> st.mem[$past(st.wAddr)] == $past(st.wData) &&
                 !st.commitPending;
  endproperty
  a_commit_word: assert property (p_commit_word)
    else $error("word not committed on opposite edge");

  property p_blocked;
    activeEdge && !wrOk |=> !st.commitPending;
  endproperty
  a_blocked: assert property (p_blocked)
    else $error("write armed without all enables");

  property p_rom_holds;
    writeDisable && !st.commitPending |=> $stable(st.mem);
  endproperty
  a_rom_holds: assert property (p_rom_holds)
    else $error("array changed while writes disabled");

  property p_new_after_commit;
    (s_commit ##0 readAddr == st.wAddr) ##1 $stable(readAddr) |->
      rdNib == $past(st.wData);
  endproperty
  a_new_after_commit: assert property (p_new_after_commit)
    else $error("read not showing committed word");

  property p_old_until_commit;
    st.commitPending && !oppEdge ##1 $stable(readAddr) |->
      rdNib == $past(rdNib);
  endproperty
  a_old_until_commit: assert property (p_old_until_commit)
    else $error("read changed before commit");

  property p_q_copy;
    activeEdge |=> {registeredOut[6], registeredOut[4], registeredOut[2],
                    registeredOut[0]} ==
                   $past({result[6], result[4], result[2], result[0]});
  endproperty
  a_q_copy: assert property (p_q_copy)
    else $error("registered output not a copy of read data");

  property p_read_follows;
    $changed(readAddr) |-> {result[6], result[4], result[2], result[0]} ==
                           st.mem[readAddr];
  endproperty
  a_read_follows: assert property (p_read_follows)
    else $error("read data not from addressed word");

  // helper views of the decode cell for the checks below
  logic [DBC_BITS-1:0] decTerm;
  logic [2:0]          decAnd;
  logic [DATA_W-1:0]   rdEven;
  logic [DATA_W-1:0]   rqEven;
  assign decTerm = leftSideIn ^ decInvert;
  assign decAnd  = {&decTerm[9:8], &decTerm[7:4], &decTerm[3:0]};
  assign rdEven  = {result[6], result[4], result[2], result[0]};
  assign rqEven  = {registeredOut[6], registeredOut[4], registeredOut[2],
                    registeredOut[0]};

  property p_const_source;
    groupDecoder == MODE_ALL_BUF |-> aoiOutput == aoiConst;
  endproperty
  a_const_source: assert property (p_const_source)
    else $error("aoi output not the constant in buffer mode");

  property p_full_and;
    groupDecoder == MODE_ALL_DEC && !aoiUseOr |->
      aoiOutput == ((&decAnd) ^ aoiInvert);
  endproperty
  a_full_and: assert property (p_full_and)
    else $error("full decoder and result wrong");

  property p_full_or;
    groupDecoder == MODE_ALL_DEC && aoiUseOr |->
      aoiOutput == ((|decAnd) ^ aoiInvert);
  endproperty
  a_full_or: assert property (p_full_or)
    else $error("full decoder or result wrong");

  property p_mode_two;
    groupDecoder == MODE_TWO && !aoiUseOr |->
      aoiOutput == (decAnd[2] ^ aoiInvert);
  endproperty
  a_mode_two: assert property (p_mode_two)
    else $error("pair-only decode result wrong");

  property p_mode_four;
    groupDecoder == MODE_FOUR && !aoiUseOr |->
      aoiOutput == ((decAnd[2] & decAnd[1]) ^ aoiInvert);
  endproperty
  a_mode_four: assert property (p_mode_four)
    else $error("six-input decode result wrong");

  property p_dec_group_silent;
    groupDecoder[2] |-> leftSideOutEn[3:0] == 4'h0 &&
                        rightSideOutEn[3:0] == 4'h0;
  endproperty
  a_dec_group_silent: assert property (p_dec_group_silent)
    else $error("decoder group still drives its buffers");

  property p_pair_no_hiz;
    !groupDecoder[0] && groupDir[8:6] == DIR_L2R |->
      rightSideOutEn[9:8] == 2'b11;
  endproperty
  a_pair_no_hiz: assert property (p_pair_no_hiz)
    else $error("pair group buffers were floated");

  property p_read_float;
    !hizControl && nibHizInvert == 2'b00 && nibHizDisable == 2'b00 &&
    nibUseAoi == 2'b00 |-> rightSideOutEn[7:0] == 8'h00 &&
                           leftSideOutEn[7:0] == 8'h00;
  endproperty
  a_read_float: assert property (p_read_float)
    else $error("read bus driven while read enable inactive");

  property p_nib_disable;
    nibHizDisable[1] && !groupDecoder[1] && groupDir[5:3] == DIR_L2R |->
      rightSideOutEn[7:4] == 4'hf;
  endproperty
  a_nib_disable: assert property (p_nib_disable)
    else $error("disabled three-state still floats nibble");

  property p_aoi_gate;
    nibUseAoi[0] && gateAoiWithHiz && !hizControl && !nibHizDisable[0] &&
    !nibHizInvert[0] |-> rightSideOutEn[3:0] == 4'h0 &&
                         leftSideOutEn[3:0] == 4'h0;
  endproperty
  a_aoi_gate: assert property (p_aoi_gate)
    else $error("gated decode enabled buffers without hiz input");

  property p_central_read;
    groupDir[2:0] == DIR_C2R |-> rightSideOut[3:0] == rdEven;
  endproperty
  a_central_read: assert property (p_central_read)
    else $error("central input not the read data");

  property p_central_reg;
    groupDir[5:3] == DIR_C2R |-> rightSideOut[7:4] == rqEven;
  endproperty
  a_central_reg: assert property (p_central_reg)
    else $error("central input not the registered data");
endmodule // dlr_logic_unit
`default_nettype wire

// *** tb/dlr_fabric_model.sv ***
// fabric model: packs address and data lines, pulses the unit clock
`timescale 1ns/100ps
`default_nettype none
module dlr_fabric_model
  import dlr_pkg::*;
(
  input  wire logic              mclk,
  input  wire logic              rst,
  input  wire logic [ADDR_W-1:0] addr,
  input  wire logic [DATA_W-1:0] wData,
  input  wire logic              pulseReq,
  input  wire logic              idleHigh,
  output logic                   pfuClk,
  output logic      [3:0]        lutInputBus,
  output logic                   fifthLutInput,
  output logic                   carryInPort,
  output logic      [7:0]        directDataIn
);
  // shared address, msb on fifth input
  assign {fifthLutInput, lutInputBus} = addr;
  assign carryInPort = addr[4];
  // address on odd bits, data on even bits
  assign directDataIn = {addr[3], wData[3], addr[2], wData[2],
                         addr[1], wData[1], addr[0], wData[0]};
  // one pulse per request, unit clock still between pulses
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      pfuClk <= 1'b0;
    end else begin
      pfuClk <= idleHigh ^ pulseReq;
    end
  end
endmodule // dlr_fabric_model
`default_nettype wire

// *** tb/dlr_logic_unit_tb_top.sv ***
// self-checking bench for the lut ram and its decode cell
`timescale 1ns/100ps
`default_nettype none
module dlr_logic_unit_tb_top;
  import dlr_pkg::*;
  localparam logic [WORDS*DATA_W-1:0] INIT =
    128'h0123_4567_89ab_cdef_fedc_ba98_7654_3210;
  // config bits: strobe en2 en3 inversions disables rom, then write expected
  localparam logic [9:0] WTAB [9] = '{10'h381, 10'h180, 10'h280, 10'h300,
    10'h071, 10'h20d, 10'h289, 10'h382, 10'h3c0};
  // decoder cases: left inputs, or, invert, expected output
  localparam logic [12:0] DTAB [5] = '{13'h1ff9, 13'h1ff0, 13'h1ff5,
    13'h0004, 13'h0007};
  logic mclk = 0, rst = 1, pulseReq = 0, idleHigh = 0, clkInvert = 0;
  logic writeStrobeInput = 0, secondPortEnable = 0, thirdPortEnable = 0;
  logic strobeInvert = 0, secondEnInvert = 0, thirdEnInvert = 0;
  logic secondEnDisable = 0, thirdEnDisable = 0, writeDisable = 0;
  logic hizControl = 0, aoiUseOr = 0, aoiInvert = 0, aoiConst = 0;
  logic gateAoiWithHiz = 0;
  logic [4:0] addr = '0;
  logic [3:0] wData = '0;
  logic [2:0] groupDecoder = '0;
  logic [8:0] groupDir = '0;
  logic [1:0] nibHizInvert = '0, nibHizDisable = '0, nibUseAoi = '0;
  logic [9:0] leftSideIn = '0, rightSideIn = '0, decInvert = '0;
  logic [9:0] leftSideOut, leftSideOutEn, rightSideOut, rightSideOutEn;
  logic [7:0] result, registeredOut, directDataIn;
  logic [3:0] lutInputBus;
  logic       pfuClk, fifthLutInput, carryInPort, aoiOutput;
  logic [3:0] mdl [32];
  int         fails = 0, samplesChecked = 0, cycles = 0;

  always #10 mclk = ~mclk;

  dlr_fabric_model fab (.mclk(mclk), .rst(rst), .addr(addr), .wData(wData),
    .pulseReq(pulseReq), .idleHigh(idleHigh), .pfuClk(pfuClk),
    .lutInputBus(lutInputBus), .fifthLutInput(fifthLutInput),
    .carryInPort(carryInPort), .directDataIn(directDataIn));

  dlr_logic_unit #(.INIT_CONTENT(INIT)) DUT (.mclk(mclk), .rst(rst),
    .pfuClk(pfuClk), .lutInputBus(lutInputBus),
    .fifthLutInput(fifthLutInput), .carryInPort(carryInPort),
    .directDataIn(directDataIn), .writeStrobeInput(writeStrobeInput),
    .secondPortEnable(secondPortEnable), .thirdPortEnable(thirdPortEnable),
    .clkInvert(clkInvert), .strobeInvert(strobeInvert),
    .secondEnInvert(secondEnInvert), .thirdEnInvert(thirdEnInvert),
    .secondEnDisable(secondEnDisable), .thirdEnDisable(thirdEnDisable),
    .writeDisable(writeDisable), .leftSideIn(leftSideIn),
    .rightSideIn(rightSideIn), .hizControl(hizControl),
    .groupDecoder(groupDecoder), .groupDir(groupDir), .decInvert(decInvert),
    .aoiUseOr(aoiUseOr), .aoiInvert(aoiInvert), .aoiConst(aoiConst),
    .nibHizInvert(nibHizInvert), .nibHizDisable(nibHizDisable),
    .nibUseAoi(nibUseAoi), .gateAoiWithHiz(gateAoiWithHiz),
    .result(result), .registeredOut(registeredOut),
    .leftSideOut(leftSideOut), .leftSideOutEn(leftSideOutEn),
    .rightSideOut(rightSideOut), .rightSideOutEn(rightSideOutEn),
    .aoiOutput(aoiOutput));

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic testDone();
    $display("checks=%0d mismatches=%0d", samplesChecked, fails);
    if (fails == 0 && samplesChecked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 2000) begin
      fails++;
      testDone();
    end
  end

  // one unit clock pulse with the address read back on the same lines
  task automatic doWrite(input logic [4:0] a, input logic [3:0] d,
                         input logic ok);
    logic [3:0] old;
    old = mdl[a];
    @(posedge mclk);
    addr <= a;
    wData <= d;
    pulseReq <= 1'b1;
    @(posedge mclk);
    pulseReq <= 1'b0;
    @(posedge mclk);
    #2;
    chk({result[6], result[4], result[2], result[0]}, old);
    @(posedge mclk);
    #2;
    chk({result[6], result[4], result[2], result[0]}, ok ? d : old);
    chk({registeredOut[6], registeredOut[4], registeredOut[2],
         registeredOut[0]}, old);
    chk({result[7], result[5], result[3], result[1]}, 4'h0);
    if (ok) begin
      mdl[a] = d;
    end
  endtask

  task automatic testInit();
    for (int i = 0; i < 32; i++) begin
      mdl[i] = INIT[4*i +: 4];
      @(posedge mclk);
      addr <= 5'(i);
      #2;
      chk({result[6], result[4], result[2], result[0]}, mdl[i]);
    end
    $display("init test done");
  endtask

  task automatic testTable();
    for (int k = 0; k < 9; k++) begin
      @(posedge mclk);
      {writeStrobeInput, secondPortEnable, thirdPortEnable, strobeInvert,
       secondEnInvert, thirdEnInvert, secondEnDisable, thirdEnDisable,
       writeDisable} <= WTAB[k][9:1];
      doWrite(5'(k + 8), mdl[k + 8] ^ 4'hf, WTAB[k][0]);
    end
    $display("enable test done");
  endtask

  // bank picked by the two port enables, third inverted, unit is bank 2
  task automatic testBank();
    for (int bank = 0; bank < 4; bank++) begin
      @(posedge mclk);
      {writeStrobeInput, strobeInvert, writeDisable} <= 3'b100;
      {secondEnDisable, thirdEnDisable} <= 2'b00;
      {secondEnInvert, thirdEnInvert} <= 2'b01;
      {secondPortEnable, thirdPortEnable} <= 2'(bank);
      doWrite(5'(bank + 20), mdl[bank + 20] ^ 4'h6, bank == 2);
    end
    $display("bank test done");
  endtask

  task automatic testClkInv();
    @(posedge mclk);
    {writeStrobeInput, secondPortEnable, thirdPortEnable, strobeInvert,
     secondEnInvert, thirdEnInvert, secondEnDisable, thirdEnDisable,
     writeDisable} <= WTAB[0][9:1];
    clkInvert <= 1'b1;
    idleHigh <= 1'b1;
    repeat (2) @(posedge mclk);
    doWrite(5'h1f, mdl[31] ^ 4'h5, 1'b1);
    @(posedge mclk);
    clkInvert <= 1'b0;
    idleHigh <= 1'b0;
    repeat (2) @(posedge mclk);
    doWrite(5'h00, mdl[0] ^ 4'ha, 1'b1);
    $display("clock polarity test done");
  endtask

  task automatic testBuf();
    @(posedge mclk);
    hizControl <= 1'b1;
    leftSideIn <= 10'h2a5;
    rightSideIn <= 10'h15a;
    #2;
    chk(rightSideOut, 10'h2a5);
    chk(rightSideOutEn, 10'h3ff);
    chk(leftSideOutEn, 10'h000);
    @(posedge mclk);
    hizControl <= 1'b0;
    #2;
    chk(rightSideOutEn, 10'h300);
    @(posedge mclk);
    nibHizInvert <= 2'b01;
    #2;
    chk(rightSideOutEn, 10'h30f);
    @(posedge mclk);
    nibHizInvert <= 2'b00;
    nibHizDisable <= 2'b10;
    #2;
    chk(rightSideOutEn, 10'h3f0);
    @(posedge mclk);
    nibHizDisable <= 2'b00;
    hizControl <= 1'b1;
    groupDir <= 9'h049;
    aoiConst <= 1'b1;
    #2;
    chk(leftSideOut, 10'h15a);
    chk(leftSideOutEn, 10'h3ff);
    chk(10'(aoiOutput), 10'h001);
    // upper central bits: captured msb, pending and old word 0, all zero
    @(posedge mclk);
    groupDir <= 9'h0db;
    #2;
    chk(rightSideOut, {6'h00, mdl[0]});
    @(posedge mclk);
    groupDir <= 9'h124;
    #2;
    chk(leftSideOut, {6'h00, mdl[0]});
    chk(leftSideOutEn & rightSideOutEn, 10'h3ff);
    $display("buffer test done");
  endtask

  task automatic testDec();
    for (int m = 0; m < 8; m++) begin
      @(posedge mclk);
      groupDecoder <= 3'(m);
      leftSideIn <= 10'h00f;
      #2;
      chk(10'(aoiOutput), (m == 0 || m == 4) ? 10'h001 : 10'h000);
    end
    for (int j = 0; j < 5; j++) begin
      @(posedge mclk);
      {leftSideIn, aoiUseOr, aoiInvert} <= DTAB[j][12:1];
      #2;
      chk(10'(aoiOutput), 10'(DTAB[j][0]));
    end
    @(posedge mclk);
    {aoiUseOr, aoiInvert, aoiConst} <= 3'h0;
    groupDecoder <= MODE_TWO;
    decInvert <= 10'h300;
    leftSideIn <= 10'h000;
    {nibUseAoi, gateAoiWithHiz, groupDir} <= {2'b01, 1'b1, 9'h000};
    #2;
    chk(10'(aoiOutput), 10'h001);
    chk(10'(rightSideOutEn[3:0]), 10'h00f);
    @(posedge mclk);
    hizControl <= 1'b0;
    #2;
    chk(10'(rightSideOutEn[3:0]), 10'h000);
    @(posedge mclk);
    hizControl <= 1'b1;
    leftSideIn <= 10'h100;
    #2;
    chk(10'(rightSideOutEn[3:0]), 10'h000);
    $display("decoder test done");
  endtask

  initial begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    testInit();
    testTable();
    testBank();
    testClkInv();
    testBuf();
    testDec();
    testDone();
  end
endmodule // dlr_logic_unit_tb_top
`default_nettype wire
